//--- hw/ltssm_debug_core.sv
// link training state machine with debug visibility: state code output,
// lane 0 training sets, forced compliance, framing-error recovery and a
// registered probe of the pipe signals. assumes the phy runs on mclk and
// that test_ctrl arrives from pins.
`timescale 1ns/10ps
`include "ltssm_cfg.svh"

// Notes on behaviour
// - detect 0/1, polling active 2, config 4
// - polling compliance reported as code 3
// - ts1 in active; ts1 and ts2 in config
// - bit 6 plus polling timeout forces compliance
// - framing error in l0 moves machine into recovery
// - pipe lane 0 signals exposed on probe
// - five-bit state code follows current state
// - machine stays in l0 with link up until a framing error
module ltssm_debug_core
    import ltssm_pkg::*;
#(
    parameter int unsigned QUIET_CYCLES  = `QUIET_CYC,
    parameter int unsigned POLL_CYCLES   = `POLL_CYC,
    parameter int unsigned CONFIG_CYCLES = `CONFIG_CYC,
    parameter int unsigned RECOV_CYCLES  = `RECOV_CYC
)
(
    input  wire logic       mclk,
    input  wire logic       rst_n,
    input  wire logic [7:0] test_ctrl,
    input  wire logic       receiver_present,
    input  wire logic       rx_elec_idle,
    input  wire logic [7:0] lane0_receive_word,
    input  wire logic       lane0_receive_k,
    output logic [4:0]      training_state,
    output logic            link_up,
    output logic [7:0]      lane0_transmit_word,
    output logic            lane0_transmit_k,
    output logic            tx_detect_rx,
    output logic            tx_elec_idle,
    output pipe_probe_t     probe
);

    ltssm_state_t state_r, state_nxt;
    logic [23:0]  tmo_r, tmo_nxt;
    logic [3:0]   cnt_r, cnt_nxt;
    logic [7:0]   test_meta_r, test_s_r;
    os_kind_t     tx_kind;
    logic         link_up_r, link_up_nxt;
    logic         det_r, det_nxt, eidle_r, eidle_nxt;
    pipe_probe_t  probe_r, probe_nxt;
    logic         rx_ts1, rx_ts2, frame_err;
    logic         expired;
    logic [7:0]   tx_word;
    logic         tx_k;

    // timeout for a state, shortened when the speed-up bit is set
    function automatic logic [23:0] limit(input ltssm_state_t st,
                                          input logic fast);
        logic [23:0] l;
        unique case (st)
            ST_DETECT_QUIET: l = QUIET_CYCLES[23:0];
            ST_POLL_ACTIVE:  l = POLL_CYCLES[23:0];
            ST_POLL_CONFIG:  l = CONFIG_CYCLES[23:0];
            ST_RECOVERY:     l = RECOV_CYCLES[23:0];
            default:         l = 24'hffffff;
        endcase
        limit = fast ? (l >> `SIM_SHIFT) : l;
    endfunction

    // ----------------------------------------------------------------
    // test control synchroniser
    // ----------------------------------------------------------------
    // static straps, but they come from pins so they get two flops
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            test_meta_r <= 8'h00;
            test_s_r    <= 8'h00;
        end
        else
        begin
            test_meta_r <= test_ctrl;
            test_s_r    <= test_meta_r;
        end
    end

    os_engine u_os (
        .mclk        (mclk),
        .rst_n       (rst_n),
        .tx_kind     (tx_kind),
        .rx_word     (lane0_receive_word),
        .rx_k        (lane0_receive_k),
        .tx_word_r   (tx_word),
        .tx_k_r      (tx_k),
        .rx_ts1_r    (rx_ts1),
        .rx_ts2_r    (rx_ts2),
        .frame_err_r (frame_err)
    );

    assign expired = tmo_r >= limit(state_r, test_s_r[`TEST_SPEEDUP]);

    // ----------------------------------------------------------------
    // training state machine
    // ----------------------------------------------------------------
    // other bits of test_ctrl are ignored, so a stray one does no harm
    always_comb
    begin
        state_nxt = state_r;
        tx_kind   = OS_IDLE;
        cnt_nxt   = cnt_r;
        unique case (state_r)
            ST_DETECT_QUIET:
                if (expired || !rx_elec_idle)
                    state_nxt = ST_DETECT_ACTIVE;
            ST_DETECT_ACTIVE:
                state_nxt = receiver_present ? ST_POLL_ACTIVE
                                             : ST_DETECT_QUIET;
            ST_POLL_ACTIVE:
            begin
                tx_kind = OS_TS1;
                if (rx_ts1 || rx_ts2)
                    cnt_nxt = cnt_r + 4'h1;
                if (cnt_r >= `TS_NEEDED)
                    state_nxt = ST_POLL_CONFIG;
                else if (expired)
                    state_nxt = test_s_r[`TEST_FORCE_CMP] ? ST_POLL_COMPL
                                                          : ST_DETECT_QUIET;
            end
            ST_POLL_COMPL:
            begin
                tx_kind = OS_COMPL;
                if (!test_s_r[`TEST_FORCE_CMP])
                    state_nxt = ST_DETECT_QUIET;
            end
            ST_POLL_CONFIG:
            begin
                tx_kind = OS_TS12;
                if (rx_ts2)
                    cnt_nxt = cnt_r + 4'h1;
                if (cnt_r >= `TS_NEEDED)
                    state_nxt = ST_L0;
                else if (expired)
                    state_nxt = ST_DETECT_QUIET;
            end
            ST_L0:  // only a framing error leaves l0
                if (frame_err)
                    state_nxt = ST_RECOVERY;
            ST_RECOVERY:
            begin
                tx_kind = OS_TS1;
                if (rx_ts1 || rx_ts2)
                    cnt_nxt = cnt_r + 4'h1;
                if (cnt_r >= `TS_NEEDED)
                    state_nxt = ST_L0;
                else if (expired)
                    state_nxt = ST_DETECT_QUIET;
            end
            default: state_nxt = ST_DETECT_QUIET;
        endcase
        // timer and set counter restart on every state change
        if (state_nxt != state_r)
        begin
            cnt_nxt = 4'h0;
            tmo_nxt = 24'h000000;
        end
        else
            tmo_nxt = (tmo_r == 24'hffffff) ? tmo_r : tmo_r + 24'h000001;
        link_up_nxt = state_nxt == ST_L0;
        det_nxt     = state_nxt == ST_DETECT_ACTIVE;
        eidle_nxt   = state_nxt == ST_DETECT_QUIET ||
                      state_nxt == ST_DETECT_ACTIVE;
    end

    // ----------------------------------------------------------------
    // probe capture
    // ----------------------------------------------------------------
    // one cycle late against the pipe, which keeps the probe timing-clean
    always_comb
    begin
        probe_nxt.tx_word      = tx_word;
        probe_nxt.tx_k         = tx_k;
        probe_nxt.rx_word      = lane0_receive_word;
        probe_nxt.rx_k         = lane0_receive_k;
        probe_nxt.rx_elec_idle = rx_elec_idle;
        probe_nxt.tx_detect_rx = det_r;
        probe_nxt.tx_elec_idle = eidle_r;
        probe_nxt.state        = state_r;
    end

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_r   <= ST_DETECT_QUIET;
            tmo_r     <= 24'h000000;
            cnt_r     <= 4'h0;
            link_up_r <= 1'b0;
            det_r     <= 1'b0;
            eidle_r   <= 1'b1;
            probe_r   <= '0;
        end
        else
        begin
            state_r   <= state_nxt;
            tmo_r     <= tmo_nxt;
            cnt_r     <= cnt_nxt;
            link_up_r <= link_up_nxt;
            det_r     <= det_nxt;
            eidle_r   <= eidle_nxt;
            probe_r   <= probe_nxt;
        end
    end

    assign training_state      = state_r;
    assign link_up             = link_up_r;
    assign lane0_transmit_word = tx_word;
    assign lane0_transmit_k    = tx_k;
    assign tx_detect_rx        = det_r;
    assign tx_elec_idle        = eidle_r;
    assign probe               = probe_r;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking dc @(posedge mclk); endclocking
    default disable iff (!rst_n);

    chk_detect_codes: assert property (
        state_r == ST_DETECT_ACTIVE |-> training_state == 5'h01 ##1
            training_state inside {5'h00, 5'h02})
        else $error("detect active code or successor wrong");
    chk_cfg_code: assert property (
        $rose(state_r == ST_POLL_CONFIG) |->
            $past(training_state) == 5'h02 && training_state == 5'h04)
        else $error("polling configuration code wrong");
    chk_compl_code: assert property (
        $rose(training_state == 5'h03) |-> $past(training_state) == 5'h02)
        else $error("compliance code 3 not entered from polling");
    chk_force_compl: assert property (
        state_r == ST_POLL_ACTIVE && expired && cnt_r < `TS_NEEDED &&
        test_s_r[`TEST_FORCE_CMP] |=> state_r == ST_POLL_COMPL)
        else $error("forced compliance not entered");
    chk_frame_recov: assert property (
        state_r == ST_L0 && frame_err |=>
            state_r == ST_RECOVERY && !link_up)
        else $error("framing error did not enter recovery");
    chk_l0_stable: assert property (
        state_r == ST_L0 && !frame_err |=> state_r == ST_L0 && link_up)
        else $error("l0 left without framing error");
    chk_probe_lane: assert property (
        ##1 probe.tx_word == $past(lane0_transmit_word) &&
            probe.rx_word == $past(lane0_receive_word))
        else $error("probe does not follow lane 0");
    chk_state_bus: assert property (
        $past(rst_n) |-> training_state == $past(state_nxt))
        else $error("state bus not following machine");

    cov_reach_l0:    cover property ($rose(state_r == ST_L0));
    cov_compliance:  cover property ($rose(state_r == ST_POLL_COMPL));
    cov_recovery:    cover property (state_r == ST_RECOVERY ##1
                                     state_r == ST_L0);

endmodule

//--- hw/ltssm_cfg.svh
// constants for the link training state reporter: state codes, ordered-set
// symbols and training timeouts; assumes a 125 MHz core clock.
`ifndef LTSSM_CFG_SVH
`define LTSSM_CFG_SVH

// ----------------------------------------------------------------
// reported state codes
// ----------------------------------------------------------------
`define CODE_DETECT_QUIET  5'h00
`define CODE_DETECT_ACTIVE 5'h01
`define CODE_POLL_ACTIVE   5'h02
`define CODE_POLL_COMPL    5'h03
`define CODE_POLL_CONFIG   5'h04
`define CODE_L0            5'h0f
`define CODE_RECOVERY      5'h0d

// ----------------------------------------------------------------
// symbols
// ----------------------------------------------------------------
`define SYM_COM      8'hbc
`define SYM_PAD      8'hf7
`define SYM_STP      8'hfb
`define SYM_SDP      8'h5c
`define SYM_END      8'hfd
`define SYM_EDB      8'hfe
`define SYM_SKP      8'h1c
`define SYM_NFTS     8'hff
`define SYM_RATE     8'h02
`define SYM_TCTL     8'h00
`define SYM_TS1_ID   8'h4a
`define SYM_TS2_ID   8'h45
`define SYM_CPAT_1   8'hb5
`define SYM_CPAT_3   8'h4a
`define SYM_IDLE     8'h00
`define TS_ID_FIRST  4'h6
`define TS_LAST      4'hf
`define TS_NEEDED    4'h8

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define CLK_MHZ        125
`define QUIET_US       12000
`define POLL_US        24000
`define CONFIG_US      48000
`define RECOV_US       24000
`define QUIET_CYC      (`QUIET_US * `CLK_MHZ)
`define POLL_CYC       (`POLL_US * `CLK_MHZ)
`define CONFIG_CYC     (`CONFIG_US * `CLK_MHZ)
`define RECOV_CYC      (`RECOV_US * `CLK_MHZ)
`define SIM_SHIFT      10
`define TEST_SPEEDUP   1
`define TEST_FORCE_CMP 6

`endif

//--- hw/ltssm_pkg.sv
// types shared by the training state reporter and its symbol engine;
// relies on the constants header for every state code.
`include "ltssm_cfg.svh"
package ltssm_pkg;

    typedef enum logic [4:0] {
        ST_DETECT_QUIET  = `CODE_DETECT_QUIET,
        ST_DETECT_ACTIVE = `CODE_DETECT_ACTIVE,
        ST_POLL_ACTIVE   = `CODE_POLL_ACTIVE,
        ST_POLL_COMPL    = `CODE_POLL_COMPL,
        ST_POLL_CONFIG   = `CODE_POLL_CONFIG,
        ST_L0            = `CODE_L0,
        ST_RECOVERY      = `CODE_RECOVERY
    } ltssm_state_t;

    typedef enum logic [2:0] {
        OS_IDLE  = 3'h0,
        OS_TS1   = 3'h1,
        OS_TS2   = 3'h2,
        OS_TS12  = 3'h3,
        OS_COMPL = 3'h4
    } os_kind_t;

    typedef struct packed {
        logic [7:0]   tx_word;
        logic         tx_k;
        logic [7:0]   rx_word;
        logic         rx_k;
        logic         rx_elec_idle;
        logic         tx_detect_rx;
        logic         tx_elec_idle;
        ltssm_state_t state;
    } pipe_probe_t;

endpackage

//--- hw/os_engine.sv
// lane 0 symbol engine: sends training ordered sets or compliance
// pattern, decodes received training sets and flags framing errors.
// assumes one symbol per mclk in both directions on the same clock.
`timescale 1ns/10ps
`include "ltssm_cfg.svh"
module os_engine
    import ltssm_pkg::*;
(
    input  wire logic       mclk,
    input  wire logic       rst_n,
    input  wire os_kind_t   tx_kind,
    input  wire logic [7:0] rx_word,
    input  wire logic       rx_k,
    output logic [7:0]      tx_word_r,
    output logic            tx_k_r,
    output logic            rx_ts1_r,
    output logic            rx_ts2_r,
    output logic            frame_err_r
);

    logic [3:0] tx_idx_r, tx_idx_nxt;
    os_kind_t   cur_r, cur_nxt;
    logic       alt_r, alt_nxt;
    logic [7:0] tx_word_nxt;
    logic       tx_k_nxt;
    logic [3:0] rx_idx_r, rx_idx_nxt;
    logic       in_os_r, in_os_nxt;
    logic       ok1_r, ok1_nxt, ok2_r, ok2_nxt;
    logic       rx_ts1_nxt, rx_ts2_nxt, frame_err_nxt;

    // k symbols that may legally appear on an up link
    function automatic logic k_legal(input logic [7:0] w);
        k_legal = (w == `SYM_COM) || (w == `SYM_STP) || (w == `SYM_SDP) ||
                  (w == `SYM_END) || (w == `SYM_EDB) || (w == `SYM_SKP) ||
                  (w == `SYM_PAD);
    endfunction

    // ----------------------------------------------------------------
    // transmit side
    // ----------------------------------------------------------------
    // kind is latched only at a set boundary so no set is ever cut short
    always_comb
    begin
        tx_idx_nxt  = tx_idx_r + 4'h1;
        cur_nxt     = cur_r;
        alt_nxt     = alt_r;
        tx_k_nxt    = 1'b0;
        tx_word_nxt = `SYM_IDLE;
        if (tx_idx_r == 4'h0)
        begin
            cur_nxt = tx_kind;
            alt_nxt = ~alt_r;
        end
        unique case (cur_nxt)
            OS_TS1, OS_TS2, OS_TS12:
            begin
                // comma and two pads are the only k symbols of a set
                tx_k_nxt = tx_idx_r < 4'h3;
                unique case (tx_idx_r)
                    4'h0:       tx_word_nxt = `SYM_COM;
                    4'h1, 4'h2: tx_word_nxt = `SYM_PAD;
                    4'h3:       tx_word_nxt = `SYM_NFTS;
                    4'h4:       tx_word_nxt = `SYM_RATE;
                    4'h5:       tx_word_nxt = `SYM_TCTL;
                    default:    // ts2 every other set while configuring
                        tx_word_nxt = (cur_nxt == OS_TS2 ||
                                       (cur_nxt == OS_TS12 && alt_nxt))
                                      ? `SYM_TS2_ID : `SYM_TS1_ID;
                endcase
            end
            OS_COMPL:
            begin
                tx_k_nxt = ~tx_idx_r[0];  // comma on every even symbol
                unique case (tx_idx_r[1:0])
                    2'h0, 2'h2: tx_word_nxt = `SYM_COM;
                    2'h1:       tx_word_nxt = `SYM_CPAT_1;
                    2'h3:       tx_word_nxt = `SYM_CPAT_3;
                endcase
            end
            default: tx_word_nxt = `SYM_IDLE;
        endcase
    end

    // ----------------------------------------------------------------
    // receive side
    // ----------------------------------------------------------------
    // checks only the identifier symbols; earlier fields vary by partner
    always_comb
    begin
        rx_idx_nxt    = rx_idx_r;
        in_os_nxt     = in_os_r;
        ok1_nxt       = ok1_r;
        ok2_nxt       = ok2_r;
        rx_ts1_nxt    = 1'b0;
        rx_ts2_nxt    = 1'b0;
        frame_err_nxt = rx_k && !k_legal(rx_word);
        if (rx_k && rx_word == `SYM_COM)
        begin
            in_os_nxt  = 1'b1;
            rx_idx_nxt = 4'h1;
            ok1_nxt    = 1'b1;
            ok2_nxt    = 1'b1;
        end
        else if (in_os_r)
        begin
            if (rx_idx_r >= `TS_ID_FIRST)
            begin
                ok1_nxt = ok1_r && !rx_k && rx_word == `SYM_TS1_ID;
                ok2_nxt = ok2_r && !rx_k && rx_word == `SYM_TS2_ID;
            end
            rx_idx_nxt = rx_idx_r + 4'h1;
            if (rx_idx_r == `TS_LAST)
            begin
                in_os_nxt  = 1'b0;
                rx_ts1_nxt = ok1_nxt;
                rx_ts2_nxt = ok2_nxt;
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            tx_idx_r    <= 4'h0;
            cur_r       <= OS_IDLE;
            alt_r       <= 1'b0;
            tx_word_r   <= 8'h00;
            tx_k_r      <= 1'b0;
            rx_idx_r    <= 4'h0;
            in_os_r     <= 1'b0;
            ok1_r       <= 1'b0;
            ok2_r       <= 1'b0;
            rx_ts1_r    <= 1'b0;
            rx_ts2_r    <= 1'b0;
            frame_err_r <= 1'b0;
        end
        else
        begin
            tx_idx_r    <= tx_idx_nxt;
            cur_r       <= cur_nxt;
            alt_r       <= alt_nxt;
            tx_word_r   <= tx_word_nxt;
            tx_k_r      <= tx_k_nxt;
            rx_idx_r    <= rx_idx_nxt;
            in_os_r     <= in_os_nxt;
            ok1_r       <= ok1_nxt;
            ok2_r       <= ok2_nxt;
            rx_ts1_r    <= rx_ts1_nxt;
            rx_ts2_r    <= rx_ts2_nxt;
            frame_err_r <= frame_err_nxt;
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    chk_ts1_ident: assert property (@(posedge mclk) disable iff (!rst_n)
        (tx_idx_r == 4'h7 && cur_r == OS_TS1) |=>
            (tx_word_r == `SYM_TS1_ID && !tx_k_r))
        else $error("ts1 identifier not sent");
    chk_set_start: assert property (@(posedge mclk) disable iff (!rst_n)
        (tx_idx_r == 4'h0 && tx_kind inside {OS_TS1, OS_TS12}) |=>
            (tx_word_r == `SYM_COM && tx_k_r) ##1 (tx_word_r == `SYM_PAD))
        else $error("training set does not open with comma and pad");

endmodule

//--- verification/root_port_model.sv
// root port stand-in: sends training sets on lane 0, can inject a bad K.
// assumes the core's mclk and one symbol per cycle in each direction.
`timescale 1ns/10ps
module root_port_model
(
    input  wire logic       mclk,
    input  wire logic       rst_n,
    input  wire logic [1:0] mode,
    input  wire logic       bad_k,
    output logic [7:0]      word,
    output logic            k
);
    logic [3:0] idx_r;

    // ----------------------------------------------------------------
    // set generator
    // ----------------------------------------------------------------
    // mode 0 sends logical idle data, so the core counts no sets
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            idx_r <= 4'h0;
            word  <= 8'h00;
            k     <= 1'b0;
        end
        else
        begin
            idx_r <= idx_r + 4'h1;
            k     <= bad_k || (mode != 2'h0 && idx_r < 4'h3);
            if (bad_k)
                word <= 8'h3c; // k code outside the legal set
            else if (mode == 2'h0)
                word <= 8'h00;
            else if (idx_r == 4'h0)
                word <= 8'hbc;
            else if (idx_r < 4'h3)
                word <= 8'hf7;
            else if (idx_r < 4'h6)
                word <= 8'h00;
            else
                word <= (mode == 2'h1) ? 8'h4a : 8'h45;
        end
    end
endmodule

//--- verification/link_training_state_debug_bench.sv
// self-checking bench for the training state reporter with short timeouts.
// assumes the root port model on lane 0 and a 125 MHz mclk.
`timescale 1ns/10ps
module link_training_state_debug_bench;
    import ltssm_pkg::*;

    logic        mclk, rst_n, receiver_present, rx_elec_idle;
    logic        bad_k, rcv_k, tx_k, det_rx, tx_idle, link_up;
    logic [7:0]  test_ctrl, rcv_word, tx_word, id0, id1;
    logic [1:0]  mode;
    logic [4:0]  training_state;
    logic [16:0] prv;
    pipe_probe_t probe;
    int          err_total, checked, cyc;

    // ----------------------------------------------------------------
    // clock, dut and far side
    // ----------------------------------------------------------------
    initial
    begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end

    // small timeouts keep the run short; the waits are fixed cycle counts sized to suit these
    ltssm_debug_core #(.QUIET_CYCLES(64), .POLL_CYCLES(300),
                       .CONFIG_CYCLES(400), .RECOV_CYCLES(300)) i_dut (
        .mclk               (mclk),
        .rst_n              (rst_n),
        .test_ctrl          (test_ctrl),
        .receiver_present   (receiver_present),
        .rx_elec_idle       (rx_elec_idle),
        .lane0_receive_word (rcv_word),
        .lane0_receive_k    (rcv_k),
        .training_state     (training_state),
        .link_up            (link_up),
        .lane0_transmit_word(tx_word),
        .lane0_transmit_k   (tx_k),
        .tx_detect_rx       (det_rx),
        .tx_elec_idle       (tx_idle),
        .probe              (probe)
    );

    root_port_model i_rp (
        .mclk (mclk),
        .rst_n(rst_n),
        .mode (mode),
        .bad_k(bad_k),
        .word (rcv_word),
        .k    (rcv_k)
    );

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    task automatic check(input string nm, input logic [31:0] seen, exp);
        checked++;
        if (seen !== exp)
        begin
            err_total++;
            $display("unexpected %s exp %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic final_report();
        $display("checked %0d err_total %0d", checked, err_total);
        if (err_total == 0 && checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // cut a hang short
    always @(posedge mclk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            err_total++;
            final_report();
        end
    end

    // wait at most n cycles for a state code, sampled mid-cycle
    task automatic wait_state(input logic [4:0] code, input int n);
        int i;
        for (i = 0; i < n && training_state !== code; i++)
            @(negedge mclk);
        check("training_state", training_state, code);
    endtask

    // find the next transmitted comma, return the id symbol of its set
    task automatic grab_set(output logic [7:0] id);
        int i;
        for (i = 0; i < 40 && !(tx_k === 1'b1 && tx_word === 8'hbc); i++)
            @(negedge mclk);
        repeat (6) @(negedge mclk);
        id = tx_word;
        for (i = 0; i < 9; i++)
        begin
            @(negedge mclk);
            check("set_symbol", tx_word, id);
        end
    endtask

    // reconfig busy stands in for the transceiver reconfiguration
    task automatic do_reset();
        logic busy;
        busy = 1'b1;
        rst_n <= 1'b0;
        repeat (2) @(posedge mclk);
        busy = 1'b0;
        @(posedge mclk);
        if (!busy)
            rst_n <= 1'b1;
        @(negedge mclk);
    endtask

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic detect_no_receiver();
        check("state_reset", training_state, 5'h00);
        check("elec_idle", tx_idle, 1'b1);
        wait_state(5'h01, 80);
        check("detect_rx", det_rx, 1'b1);
        @(negedge mclk);
        check("back_quiet", training_state, 5'h00);
    endtask

    task automatic train_to_l0();
        receiver_present <= 1'b1;
        rx_elec_idle <= 1'b0;
        wait_state(5'h02, 20);
        grab_set(id0);
        check("active_set", id0, 8'h4a);
        mode <= 2'h1;
        wait_state(5'h04, 200);
        mode <= 2'h2;
        @(negedge mclk); // skip a comma latched while still polling
        grab_set(id0);
        grab_set(id1);
        check("config_pair", {id0, id1} == 16'h4a45
              || {id0, id1} == 16'h454a, 1'b1);
        wait_state(5'h0f, 200);
        repeat (100) @(negedge mclk);
        check("l0_stable", {training_state, link_up}, 6'h1f);
    endtask

    task automatic probe_follows();
        int i;
        for (i = 0; i < 20; i++)
        begin
            prv = {tx_word, rcv_word, training_state[0]};
            @(negedge mclk);
            check("probe", {probe.tx_word, probe.rx_word,
                            probe.state[0]}, prv);
            check("probe_state", probe.state, training_state);
        end
    endtask

    task automatic framing_error();
        @(posedge mclk);
        bad_k <= 1'b1;
        @(posedge mclk);
        bad_k <= 1'b0;
        mode <= 2'h1;
        wait_state(5'h0d, 6);
        wait_state(5'h0f, 200);
    endtask

    task automatic forced_compliance();
        int i;
        mode <= 2'h0;
        test_ctrl <= 8'h42;
        do_reset();
        wait_state(5'h02, 20);
        // speed-up shifts the 300-cycle polling timeout down to zero
        wait_state(5'h03, 4);
        for (i = 0; i < 20 && !(tx_k === 1'b1 && tx_word === 8'hbc); i++)
            @(negedge mclk);
        @(negedge mclk);
        check("cpat_1", tx_word, 8'hb5);
        @(negedge mclk);
        check("cpat_2", {tx_k, tx_word}, 9'h1bc);
        @(posedge mclk);
        test_ctrl <= 8'h00;
        wait_state(5'h00, 8);
    endtask

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial
    begin
        err_total = 0;
        checked = 0;
        cyc = 0;
        rst_n = 1'b0;
        test_ctrl = 8'h00;
        receiver_present = 1'b0;
        rx_elec_idle = 1'b1;
        mode = 2'h0;
        bad_k = 1'b0;
        do_reset();
        detect_no_receiver();
        train_to_l0();
        probe_follows();
        framing_error();
        forced_compliance();
        final_report();
    end
endmodule
